//--- hdl/htf_edge_rate.sv
// decoder turning a 2-bit edge-rate code into mV/ns
module htf_edge_rate
	import htf_pkg::*;
(
	input  wire logic [1:0] code,
	output logic      [6:0] rateMvNs
);
	// ==========================================================
	// code 00..11 gives 25,50,75,100
	assign rateMvNs = 7'((int'(code) + 1) * EDGE_RATE_STEP_MVNS);
endmodule : htf_edge_rate

//--- hdl/htf_pkg.sv
// package with register map, field positions and reset values of the trim/fault/snippet bank
package htf_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_EDGE_TRIM    = 8'h62;
	localparam logic [7:0] ADDR_CFG_FIVE     = 8'h6E;
	localparam logic [7:0] ADDR_FAULT_EVENT  = 8'h81;
	localparam logic [7:0] ADDR_STATUS_TWO   = 8'h82;
	localparam logic [7:0] ADDR_MASK_TWO     = 8'h83;
	localparam logic [7:0] ADDR_SNIP_FIRST   = 8'h84;
	localparam logic [7:0] ADDR_SNIP_LAST    = 8'hE7;
	localparam int         SNIP_DEPTH        = 100;

	// ==========================================================
	// field positions
	localparam int BIT_LS_RATE_LO   = 2;
	localparam int BIT_HS_RATE_LO   = 0;
	localparam int BIT_BYPASS       = 2;
	localparam int BIT_FREQ_HOLD    = 1;
	localparam int BIT_OFFSET_EN    = 0;
	localparam int BIT_SAT_FLAG     = 2;
	localparam int BIT_SAT_STATE    = 7;
	localparam int BIT_SAT_MASK     = 7;

	// ==========================================================
	// reset values
	localparam logic [1:0] RST_EDGE_RATE  = 2'h3;
	localparam logic       RST_BYPASS     = 1'h0;
	localparam logic       RST_FREQ_HOLD  = 1'h0;
	localparam logic       RST_OFFSET_EN  = 1'h1;
	localparam logic       RST_SAT        = 1'h0;
	localparam logic [7:0] RST_SNIP       = 8'h00;

	// ==========================================================
	// edge-rate step in mV/ns and offset in mV
	localparam int EDGE_RATE_STEP_MVNS = 25;
	localparam int CONV_OFFSET_MV      = 50;

endpackage : htf_pkg

//--- hdl/htf_regs.sv
// register bank: edge-rate trims, drive config, saturation fault and snippet memory
// Operation
// - hundred snippet bytes, read-write, reset zero
// - saturation sets sticky flag, write-one clears
// - status bit follows live saturation condition
// - mask bit read-write, reset unmasked
// - hold frequency update on polarity reversal
// - offset enable adds fixed conversion offset
// - bypass bit skips delay comparator
// - low-side edge rate code decoded
// - high-side edge rate code decoded
//
// Design decision made here: the strobed register port.
module htf_regs
	import htf_pkg::*;
#(
	parameter int DEPTH = SNIP_DEPTH
)
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStrobe,
	input  wire logic       rdStrobe,
	output logic      [7:0] rdData,
	input  wire logic       converterSaturated,
	input  wire logic       polarityReversal,
	input  wire logic       freqUpdateRequest,
	output logic            freqUpdateEnable,
	output logic      [6:0] lowSideRateMvNs,
	output logic      [6:0] highSideRateMvNs,
	output logic      [5:0] conversionOffsetMv,
	output logic            delayComparatorBypass,
	output logic            irq
);

	// ==========================================================
	// elaboration check
	if (DEPTH != int'(ADDR_SNIP_LAST) - int'(ADDR_SNIP_FIRST) + 1) begin : g_depth_check
		$error("snippet depth must match the address range");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0] lowSideEdgeRate;
		logic [1:0] highSideEdgeRate;
		logic       delayBypass;
		logic       freqHoldOnReversal;
		logic       conversionFactorOffsetEnable;
		logic       converterSaturationFlag;
		logic       converterSaturationState;
		logic       converterSaturationMask;
		logic [7:0] rdData;
		logic [DEPTH-1:0][7:0] snippet;
	} htf_state_t;

	htf_state_t state;
	htf_state_t next_state;

	// ==========================================================
	// address helpers
	function automatic logic isSnippet(input logic [7:0] a);
		isSnippet = (a >= ADDR_SNIP_FIRST) && (a <= ADDR_SNIP_LAST);
	endfunction : isSnippet

	function automatic logic [6:0] snippetIndex(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_SNIP_FIRST;
		snippetIndex = d[6:0];
	endfunction : snippetIndex

	// ==========================================================
	// next-state logic
	always_comb begin
		next_state = state;
		next_state.converterSaturationState = converterSaturated;
		if (wrStrobe && addr == ADDR_FAULT_EVENT && wrData[BIT_SAT_FLAG]) begin
			next_state.converterSaturationFlag = 1'h0;
		end
		if (converterSaturated) begin
			next_state.converterSaturationFlag = 1'h1;
		end
		if (wrStrobe) begin
			case (addr)
				ADDR_EDGE_TRIM: begin
					next_state.lowSideEdgeRate = wrData[BIT_LS_RATE_LO +: 2];
					next_state.highSideEdgeRate = wrData[BIT_HS_RATE_LO +: 2];
				end
				ADDR_CFG_FIVE: begin
					next_state.delayBypass = wrData[BIT_BYPASS];
					next_state.freqHoldOnReversal = wrData[BIT_FREQ_HOLD];
					next_state.conversionFactorOffsetEnable = wrData[BIT_OFFSET_EN];
				end
				ADDR_MASK_TWO: begin
					next_state.converterSaturationMask = wrData[BIT_SAT_MASK];
				end
				default: begin
					if (isSnippet(addr)) begin
						next_state.snippet[snippetIndex(addr)] = wrData;
					end
				end
			endcase
		end
		next_state.rdData = 8'h00;
		if (rdStrobe) begin
			case (addr)
				ADDR_EDGE_TRIM: begin
					next_state.rdData[BIT_LS_RATE_LO +: 2] = state.lowSideEdgeRate;
					next_state.rdData[BIT_HS_RATE_LO +: 2] = state.highSideEdgeRate;
				end
				ADDR_CFG_FIVE: begin
					next_state.rdData[BIT_BYPASS]    = state.delayBypass;
					next_state.rdData[BIT_FREQ_HOLD] = state.freqHoldOnReversal;
					next_state.rdData[BIT_OFFSET_EN] = state.conversionFactorOffsetEnable;
				end
				ADDR_FAULT_EVENT: begin
					next_state.rdData[BIT_SAT_FLAG] = state.converterSaturationFlag;
				end
				ADDR_STATUS_TWO: begin
					next_state.rdData[BIT_SAT_STATE] = state.converterSaturationState;
				end
				ADDR_MASK_TWO: begin
					next_state.rdData[BIT_SAT_MASK] = state.converterSaturationMask;
				end
				default: begin
					if (isSnippet(addr)) begin
						next_state.rdData = state.snippet[snippetIndex(addr)];
					end
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state.lowSideEdgeRate              <= RST_EDGE_RATE;
			state.highSideEdgeRate             <= RST_EDGE_RATE;
			state.delayBypass                  <= RST_BYPASS;
			state.freqHoldOnReversal           <= RST_FREQ_HOLD;
			state.conversionFactorOffsetEnable <= RST_OFFSET_EN;
			state.converterSaturationFlag      <= RST_SAT;
			state.converterSaturationState     <= RST_SAT;
			state.converterSaturationMask      <= RST_SAT;
			state.rdData                       <= 8'h00;
			state.snippet                      <= {DEPTH{RST_SNIP}};
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// outputs
	assign rdData = state.rdData;
	assign freqUpdateEnable = freqUpdateRequest && !(state.freqHoldOnReversal && polarityReversal);
	assign conversionOffsetMv = state.conversionFactorOffsetEnable ? 6'(CONV_OFFSET_MV) : 6'h00;
	assign delayComparatorBypass = state.delayBypass;
	assign irq = state.converterSaturationFlag && !state.converterSaturationMask;

	// ==========================================================
	// edge-rate decoders
	// low side decode
	htf_edge_rate u_lowSide (
		.code     (state.lowSideEdgeRate),
		.rateMvNs (lowSideRateMvNs)
	);
	htf_edge_rate u_highSide (
		.code     (state.highSideEdgeRate),
		.rateMvNs (highSideRateMvNs)
	);

endmodule : htf_regs

//--- test/htf_regs_props.sv
// checker of the bank port behaviour
module htf_regs_props
	import htf_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	input wire logic       wrStrobe,
	input wire logic       rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic       converterSaturated,
	input wire logic       polarityReversal,
	input wire logic       freqUpdateRequest,
	input wire logic       freqUpdateEnable,
	input wire logic [6:0] lowSideRateMvNs,
	input wire logic [6:0] highSideRateMvNs,
	input wire logic [5:0] conversionOffsetMv,
	input wire logic       delayComparatorBypass,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// port properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic trimWr = wrStrobe && addr == ADDR_EDGE_TRIM;
	wire logic cfgWr  = wrStrobe && addr == ADDR_CFG_FIVE;
	wire logic clrWr  = wrStrobe && addr == ADDR_FAULT_EVENT;
	wire logic mskWr  = wrStrobe && addr == ADDR_MASK_TWO;
	wire logic staRd  = rdStrobe && addr == ADDR_STATUS_TWO;
	wire logic evtRd  = rdStrobe && addr == ADDR_FAULT_EVENT;
	a_read_idle_zero: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("read data not zero");
	a_low_rate_set: assert property (trimWr |=> lowSideRateMvNs == ($past(wrData[3:2]) + 7'h1) * 7'h19)
		else $error("low side rate wrong");
	a_high_rate_set: assert property (trimWr |=> highSideRateMvNs == ($past(wrData[1:0]) + 7'h1) * 7'h19)
		else $error("high side rate wrong");
	a_offset_set: assert property (cfgWr |=> conversionOffsetMv == ($past(wrData[0]) ? 6'h32 : 6'h00))
		else $error("offset wrong");
	a_bypass_set: assert property (cfgWr |=> delayComparatorBypass == $past(wrData[2]))
		else $error("bypass wrong");
	a_hold_on_reversal: assert property (cfgWr && wrData[1] ##1 polarityReversal |-> !freqUpdateEnable)
		else $error("update not held");
	a_update_passes: assert property (!polarityReversal |-> freqUpdateEnable == freqUpdateRequest)
		else $error("update not passed");
	a_irq_sticky: assert property (irq && !clrWr && !mskWr |=> irq)
		else $error("irq dropped");
	a_irq_cause: assert property ($rose(irq) |-> $past(converterSaturated) || $past(mskWr))
		else $error("irq without cause");
	a_clear_drops_irq: assert property (clrWr && wrData[2] && !converterSaturated |=> !irq)
		else $error("irq not cleared");
	a_status_read: assert property (staRd |=> rdData == {$past(converterSaturated, 2), 7'h00})
		else $error("status read wrong");
	a_event_reserved: assert property (evtRd |=> (rdData & 8'hFB) == 8'h00)
		else $error("event reserved bits set");
endmodule : htf_regs_props

bind htf_regs htf_regs_props u_htf_regs_props (.clk, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
	.converterSaturated, .polarityReversal, .freqUpdateRequest, .freqUpdateEnable, .lowSideRateMvNs,
	.highSideRateMvNs, .conversionOffsetMv, .delayComparatorBypass, .irq);

//--- test/test_htf_regs.sv
// self-checking bench of the trim, fault and snippet bank
module test_htf_regs
	import htf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a, d, e;} htf_row_t;
	logic       clk = 1'h0, reset_n, wrStrobe, rdStrobe, converterSaturated, polarityReversal, freqUpdateRequest;
	logic       freqUpdateEnable, delayComparatorBypass, irq;
	logic [7:0] addr, wrData, rdData;
	logic [6:0] lowSideRateMvNs, highSideRateMvNs;
	logic [5:0] conversionOffsetMv;
	int         numErrors = 0, numChecks = 0;
	htf_row_t   rows [13] = '{'{8'h62, 8'h00, 8'h00}, '{8'h62, 8'h06, 8'h06}, '{8'h62, 8'h09, 8'h09},
		'{8'h62, 8'hFF, 8'h0F}, '{8'h6E, 8'h07, 8'h07}, '{8'h6E, 8'hF8, 8'h00}, '{8'h83, 8'hFF, 8'h80},
		'{8'h84, 8'hA5, 8'hA5}, '{8'hB6, 8'h3C, 8'h3C}, '{8'hE7, 8'h5A, 8'h5A}, '{8'h70, 8'hFF, 8'h00},
		'{8'hE8, 8'hFF, 8'h00}, '{8'h82, 8'hFF, 8'h00}};
	htf_regs u_htf_regs (.clk, .reset_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .converterSaturated,
		.polarityReversal, .freqUpdateRequest, .freqUpdateEnable, .lowSideRateMvNs, .highSideRateMvNs,
		.conversionOffsetMv, .delayComparatorBypass, .irq);
	always #20 clk = ~clk;
	// ==========================================================
	// check, bus and summary tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		numChecks++;
		if (s !== e) begin
			numErrors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'h1;
		@(posedge clk);
		wrStrobe <= 1'h0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'h1;
		@(posedge clk);
		rdStrobe <= 1'h0;
		#1;
		chk("rdData", e, rdData);
	endtask : rd
	task automatic summarize();
		if (numErrors == 0 && numChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	// ==========================================================
	// main sequence
	initial begin
		{reset_n, wrStrobe, rdStrobe, converterSaturated, polarityReversal, freqUpdateRequest} = 6'h00;
		addr = 8'h00;
		wrData = 8'h00;
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		@(posedge clk);
		reset_n <= 1'h0;
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		rd(ADDR_EDGE_TRIM, 8'h0F);
		rd(ADDR_CFG_FIVE, 8'h01);
		rd(ADDR_MASK_TWO, 8'h00);
		rd(8'hB6, 8'h00);
		chk("conversionOffsetMv", 8'h32, {2'h0, conversionOffsetMv});
		chk("lowSideRateMvNs", 8'h64, {1'h0, lowSideRateMvNs});
		chk("highSideRateMvNs", 8'h64, {1'h0, highSideRateMvNs});
		@(posedge clk);
		converterSaturated <= 1'h1;
		rd(ADDR_STATUS_TWO, 8'h80);
		@(posedge clk);
		converterSaturated <= 1'h0;
		rd(ADDR_FAULT_EVENT, 8'h04);
		rd(ADDR_STATUS_TWO, 8'h00);
		chk("irq", 8'h01, {7'h0, irq});
		wr(ADDR_MASK_TWO, 8'h80);
		chk("irq", 8'h00, {7'h0, irq});
		wr(ADDR_FAULT_EVENT, 8'h00);
		rd(ADDR_FAULT_EVENT, 8'h04);
		wr(ADDR_MASK_TWO, 8'h00);
		chk("irq", 8'h01, {7'h0, irq});
		wr(ADDR_FAULT_EVENT, 8'h04);
		chk("irq", 8'h00, {7'h0, irq});
		rd(ADDR_FAULT_EVENT, 8'h00);
		// saturation in the clear cycle keeps the flag
		@(posedge clk);
		converterSaturated <= 1'h1;
		wr(ADDR_FAULT_EVENT, 8'h04);
		@(posedge clk);
		converterSaturated <= 1'h0;
		rd(ADDR_FAULT_EVENT, 8'h04);
		wr(ADDR_FAULT_EVENT, 8'h04);
		rd(ADDR_FAULT_EVENT, 8'h00);
		@(posedge clk);
		freqUpdateRequest <= 1'h1;
		polarityReversal <= 1'h1;
		#1;
		chk("freqUpdateEnable", 8'h01, {7'h0, freqUpdateEnable});
		wr(ADDR_CFG_FIVE, 8'h02);
		chk("freqUpdateEnable", 8'h00, {7'h0, freqUpdateEnable});
		chk("conversionOffsetMv", 8'h00, {2'h0, conversionOffsetMv});
		wr(ADDR_CFG_FIVE, 8'h04);
		chk("freqUpdateEnable", 8'h01, {7'h0, freqUpdateEnable});
		chk("delayComparatorBypass", 8'h01, {7'h0, delayComparatorBypass});
		summarize();
	end
endmodule : test_htf_regs
